//--- rtl/tsp_top.sv
//Behaviour
// RQ1: after a transfer the device sleeps until slave select rises
// RQ2: touch and ready outputs float for the wake interval after sleep
// RQ3: slave select pin is pulled low 250 ns when leaving sleep
// RQ4: serial clock activity wakes the device, then it waits for select rise
// RQ5: host should not toggle serial clock before select falls
// RQ6: touch output high while detected, mirrored in response bit 7
// RQ7: detection only on channel imbalance, never on an equal shift
// RQ8: position visible only while touch is detected
// RQ9: left end 0, right end 127, taps at 45 and 83
// RQ10: position computed continuously, returned on status command; code gives it only on position_out, status byte holds bits 7 and 1
// RQ11: outer tenth at each end saturates to 0 or 127
// RQ12: position follows each burst, stops when detection is lost
// RQ13: calibration at power up and on command code 0x01
// RQ14: commanded calibration runs 10 bursts spaced 1 ms
// RQ15: power up calibration adds 6 bursts
// RQ16: no communication and ready low during calibration
// RQ17: error flag bit 1 set when a calibrated-away finger leaves
// RQ18: host checks first detection after calibration, recalibrates on error
// RQ19: drift command moves references toward the measurement
// RQ20: host sets detection threshold
// RQ21: sync mode bursts once after select falls then rises
// RQ22: select high free runs a burst every 30 ms without sleep
// RQ23: ready high only when communication is possible
// RQ24: extra 500 us settle after wake, skipped without sleep
// RQ25: presence and position from three channels against references per burst
`timescale 1ns/100ps
module tsp_top
  import tsp_pkg::*;
#(
  parameter int T_FLOAT = FLOAT_CYC,
  parameter int T_SETTLE = SETTLE_CYC,
  parameter int T_FREERUN = FREERUN_CYC,
  parameter int T_CAL_GAP = CAL_GAP_CYC,
  parameter int T_SLEEP_ENTRY = SLEEP_ENTRY_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ss_n_pin_in,
  output logic ss_n_pin_out,
  output logic ss_n_pin_oe,
  input wire logic sclk_pin_in,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] threshold,
  output logic burst_req,
  input wire logic burst_done,
  input tsp_meas_t burst_meas,
  output logic comm_ready_out,
  output logic comm_ready_oe,
  output logic touch_out,
  output logic touch_oe,
  output logic sleep_out,
  output logic calibrating,
  output logic [6:0] position_out,
  output logic [7:0] response_byte
);
  tsp_state_t state_reg, state_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [4:0] cal_left_reg, cal_left_next;
  logic xfer_seen_reg, xfer_seen_next;
  logic cal_pending_reg;
  logic cal_first_reg;
  logic [7:0] diag_reg;
  logic ss_d_reg, sclk_d_reg;
  tsp_meas_t ref_reg, last_reg;
  logic detect_reg, err_reg, armed_reg;
  logic [6:0] pos_reg;
  logic [1:0] pins_sync;
  logic pos_detect, pos_inverted;
  logic [6:0] pos_value;

  function automatic logic [MEAS_W-1:0] step_toward(input logic [MEAS_W-1:0] r,
                                                   input logic [MEAS_W-1:0] m);
    step_toward = (m > r) ? r + 1'b1 : (m < r) ? r - 1'b1 : r;
  endfunction : step_toward

  tsp_sync #(.WIDTH(2)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({ss_n_pin_in, sclk_pin_in}),
    .sync_out(pins_sync)
  );

  tsp_pos u_pos (
    .meas(burst_meas),
    .refv(ref_reg),
    .threshold(threshold),
    .detect(pos_detect),
    .inverted(pos_inverted),
    .position(pos_value)
  );

  wire ss_s = pins_sync[1];
  wire sclk_s = pins_sync[0];
  wire ss_rise = ss_s && !ss_d_reg;
  wire ss_fall = !ss_s && ss_d_reg;
  wire sclk_edge = sclk_s ^ sclk_d_reg;
  wire st_idle = (state_reg == ST_IDLE);
  wire st_frame = (state_reg == ST_FRAME);
  wire st_sleep = (state_reg == ST_SLEEP);
  wire st_float = (state_reg == ST_FLOAT);
  wire st_settle = (state_reg == ST_SETTLE);
  wire st_burst = (state_reg == ST_BURST);
  wire st_cal = (state_reg == ST_CAL_GAP) || (state_reg == ST_CAL_BURST);
  wire timer_zero = (timer_reg == '0);
  wire cmd_ok = st_frame && cmd_valid;
  wire cmd_cal = cmd_ok && (cmd_code == CMD_CAL);
  wire cmd_drift = cmd_ok && (cmd_code == CMD_DRIFT);
  wire cmd_status = cmd_ok && (cmd_code == CMD_STATUS);
  wire wake = st_sleep && (ss_rise || sclk_edge);
  wire run_done = st_burst && burst_done;
  wire cal_done = (state_reg == ST_CAL_BURST) && burst_done;

  always_comb begin
    state_next = state_reg;
    timer_next = timer_zero ? timer_reg : timer_reg - 1'b1;
    cal_left_next = cal_left_reg;
    xfer_seen_next = xfer_seen_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ss_fall) begin
          state_next = ST_FRAME;
          xfer_seen_next = 1'b0;
        end else if (timer_zero) begin
          state_next = ST_BURST; // see RQ22
        end
      end
      ST_FRAME: begin
        if (sclk_edge) begin
          xfer_seen_next = 1'b1;
          timer_next = TIMER_W'(T_SLEEP_ENTRY - 1);
        end
        if (ss_rise) begin
          state_next = (cal_pending_reg || cmd_cal) ? ST_CAL_GAP : ST_BURST; // see RQ21
          timer_next = TIMER_W'(T_CAL_GAP - 1);
          cal_left_next = CAL_BURSTS_CMD; // see RQ14
        end else if (xfer_seen_reg && timer_zero && !sclk_edge) begin
          state_next = ST_SLEEP; // see RQ1
        end
      end
      ST_SLEEP: begin
        if (ss_rise) begin
          state_next = ST_FLOAT;
          timer_next = TIMER_W'(T_FLOAT - 1);
        end else if (sclk_edge) begin
          state_next = ST_HOLD; // see RQ4
        end
      end
      ST_HOLD: begin
        if (ss_rise) begin
          state_next = ST_FLOAT;
          timer_next = TIMER_W'(T_FLOAT - 1);
        end
      end
      ST_FLOAT: begin
        if (timer_zero) begin
          state_next = ST_SETTLE; // see RQ24
          timer_next = TIMER_W'(T_SETTLE - 1);
        end
      end
      ST_SETTLE: begin
        if (timer_zero) begin
          state_next = cal_pending_reg ? ST_CAL_GAP : ST_BURST;
          timer_next = TIMER_W'(T_CAL_GAP - 1);
          cal_left_next = CAL_BURSTS_CMD;
        end
      end
      ST_BURST: begin
        if (burst_done) begin
          state_next = ST_IDLE;
          timer_next = TIMER_W'(T_FREERUN - 1);
        end
      end
      ST_CAL_GAP: begin
        if (timer_zero) begin
          state_next = ST_CAL_BURST;
        end
      end
      ST_CAL_BURST: begin
        if (burst_done) begin
          cal_left_next = cal_left_reg - 1'b1;
          state_next = (cal_left_reg == 5'h01) ? ST_IDLE : ST_CAL_GAP;
          timer_next = (cal_left_reg == 5'h01) ? TIMER_W'(T_FREERUN - 1) :
                                                 TIMER_W'(T_CAL_GAP - 1);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // power up begins with the long calibration (see RQ13) (see RQ15)
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_CAL_GAP;
      timer_reg <= TIMER_W'(T_CAL_GAP - 1);
      cal_left_reg <= CAL_BURSTS_PWR;
      xfer_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      cal_left_reg <= cal_left_next;
      xfer_seen_reg <= xfer_seen_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ss_d_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
      diag_reg <= '0;
      cal_pending_reg <= 1'b0;
    end else begin
      ss_d_reg <= ss_s;
      sclk_d_reg <= sclk_s;
      diag_reg <= wake ? 8'(DIAG_CYC) : (diag_reg != '0) ? diag_reg - 1'b1 : diag_reg; // see RQ3
      cal_pending_reg <= cmd_cal ? 1'b1 : st_cal ? 1'b0 : cal_pending_reg; // see RQ13
    end
  end

  // references, drift and results
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_reg <= '0;
      last_reg <= '0;
      cal_first_reg <= 1'b1;
    end else begin
      if (cal_done) begin
        last_reg <= burst_meas;
        cal_first_reg <= 1'b0;
        ref_reg.ch_left <= cal_first_reg ? burst_meas.ch_left :
          MEAS_W'(({1'b0, ref_reg.ch_left} + {1'b0, burst_meas.ch_left}) >> 1);
        ref_reg.ch_right <= cal_first_reg ? burst_meas.ch_right :
          MEAS_W'(({1'b0, ref_reg.ch_right} + {1'b0, burst_meas.ch_right}) >> 1);
        ref_reg.ch_ends <= cal_first_reg ? burst_meas.ch_ends :
          MEAS_W'(({1'b0, ref_reg.ch_ends} + {1'b0, burst_meas.ch_ends}) >> 1);
      end else if (cmd_drift) begin
        ref_reg.ch_left <= step_toward(ref_reg.ch_left, last_reg.ch_left); // see RQ19
        ref_reg.ch_right <= step_toward(ref_reg.ch_right, last_reg.ch_right);
        ref_reg.ch_ends <= step_toward(ref_reg.ch_ends, last_reg.ch_ends);
      end else if (run_done) begin
        last_reg <= burst_meas;
      end
      if (cmd_cal) begin
        cal_first_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      detect_reg <= 1'b0;
      pos_reg <= '0;
      err_reg <= 1'b0;
      armed_reg <= 1'b1;
      response_byte <= '0;
    end else begin
      if (run_done) begin
        detect_reg <= pos_detect; // see RQ7 see RQ25 see RQ20
        pos_reg <= pos_detect ? pos_value : POS_LEFT; // see RQ12 see RQ9
      end
      if (st_cal) begin
        detect_reg <= 1'b0;
        armed_reg <= 1'b1;
      end else if (run_done && pos_detect && armed_reg) begin
        armed_reg <= 1'b0;
      end
      // first detection after calibration; set wins over clear
      if (run_done && pos_detect && armed_reg && pos_inverted) begin
        err_reg <= 1'b1; // see RQ17
      end else if (cmd_cal) begin
        err_reg <= 1'b0;
      end
      if (cmd_status) begin
        response_byte <= '0;
        response_byte[RESP_DETECT_BIT] <= detect_reg; // see RQ6
        response_byte[RESP_ERROR_BIT] <= err_reg;
      end
    end
  end

  assign position_out = detect_reg ? pos_reg : POS_LEFT; // see RQ8 see RQ10
  assign touch_out = detect_reg; // see RQ6
  assign touch_oe = !st_float; // see RQ2
  assign comm_ready_out = st_idle || st_frame; // see RQ23 see RQ16
  assign comm_ready_oe = !st_float;
  assign ss_n_pin_out = 1'b0;
  assign ss_n_pin_oe = (diag_reg != '0);
  assign sleep_out = st_sleep;
  assign calibrating = st_cal;
  assign burst_req = st_burst || (state_reg == ST_CAL_BURST);

  // helpers for checks
  logic [TIMER_W-1:0] dwell_reg;
  logic [7:0] diag_len_reg;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dwell_reg <= TIMER_W'(1);
      diag_len_reg <= '0;
    end else begin
      dwell_reg <= (state_next != state_reg) ? TIMER_W'(1) : dwell_reg + 1'b1;
      diag_len_reg <= ss_n_pin_oe ? diag_len_reg + 1'b1 : '0;
    end
  end

  chk_float_undriven: assert property (@(posedge sys_clk) disable iff (reset) // see RQ2
    st_float |-> !comm_ready_oe && !touch_oe)
    else $error("outputs driven during wake float");
  chk_float_length: assert property (@(posedge sys_clk) disable iff (reset) // see RQ2
    $fell(st_float) |-> $past(dwell_reg) == TIMER_W'(T_FLOAT) && st_settle)
    else $error("wake float interval wrong");
  chk_settle_length: assert property (@(posedge sys_clk) disable iff (reset) // see RQ24
    $fell(st_settle) |-> $past(dwell_reg) == TIMER_W'(T_SETTLE))
    else $error("settle interval wrong");
  chk_diag_pulse: assert property (@(posedge sys_clk) disable iff (reset) // see RQ3
    $fell(ss_n_pin_oe) |-> diag_len_reg == 8'(DIAG_CYC) && !ss_n_pin_out)
    else $error("diagnostic pulse length wrong");
  chk_wake_pulse: assert property (@(posedge sys_clk) disable iff (reset) // see RQ3
    $fell(st_sleep) |-> ss_n_pin_oe)
    else $error("no diagnostic pulse on wake");
  chk_sclk_wake: assert property (@(posedge sys_clk) disable iff (reset) // see RQ4
    st_sleep && sclk_edge && !ss_rise |=> state_reg == ST_HOLD ##1 !st_burst)
    else $error("serial clock did not wake");
  chk_cal_silent: assert property (@(posedge sys_clk) disable iff (reset) // see RQ16
    st_cal |-> !comm_ready_out && !(cmd_ok))
    else $error("ready high during calibration");
  chk_pos_hidden: assert property (@(posedge sys_clk) disable iff (reset) // see RQ8
    !touch_out |-> position_out == POS_LEFT)
    else $error("position shown without touch");
  chk_status_mirror: assert property (@(posedge sys_clk) disable iff (reset) // see RQ6
    cmd_status |=> response_byte[RESP_DETECT_BIT] == $past(touch_out))
    else $error("response bit 7 not mirroring touch");
  chk_freerun_burst: assert property (@(posedge sys_clk) disable iff (reset) // see RQ22
    st_idle && timer_zero && !ss_fall |=> st_burst && burst_req)
    else $error("free run burst missed");
endmodule : tsp_top

//--- rtl/tsp_pkg.sv
package tsp_pkg;
  // clock and times
  localparam int CLK_MHZ = 250;
  localparam int FLOAT_US = 400;
  localparam int SETTLE_US = 500;
  localparam int DIAG_NS = 250;
  localparam int FREERUN_MS = 30;
  localparam int CAL_GAP_MS = 1;
  localparam int SLEEP_ENTRY_US = 35;
  localparam int FLOAT_CYC = FLOAT_US * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int DIAG_CYC = (DIAG_NS * CLK_MHZ + 999) / 1000;
  localparam int FREERUN_CYC = FREERUN_MS * 1000 * CLK_MHZ;
  localparam int CAL_GAP_CYC = CAL_GAP_MS * 1000 * CLK_MHZ;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
  localparam int TIMER_W = 24;
  // calibration burst counts
  localparam logic [4:0] CAL_BURSTS_CMD = 5'h0a;
  localparam logic [4:0] CAL_BURSTS_PWR = 5'h10;
  // host command codes
  localparam logic [7:0] CMD_CAL = 8'h01;
  localparam logic [7:0] CMD_DRIFT = 8'h03;
  localparam logic [7:0] CMD_STATUS = 8'h00;
  // response byte fields
  localparam int RESP_DETECT_BIT = 7;
  localparam int RESP_ERROR_BIT = 1;
  // position encoding
  localparam logic [6:0] POS_LEFT = 7'h00;
  localparam logic [6:0] POS_TAP_LEFT = 7'h2d;
  localparam logic [6:0] POS_TAP_RIGHT = 7'h53;
  localparam logic [6:0] POS_RIGHT = 7'h7f;
  localparam logic [6:0] POS_STOP_LO = 7'h0c;
  localparam logic [6:0] POS_STOP_HI = 7'h73;
  localparam int MEAS_W = 16;

  typedef struct packed {
    logic [MEAS_W-1:0] ch_left;
    logic [MEAS_W-1:0] ch_right;
    logic [MEAS_W-1:0] ch_ends;
  } tsp_meas_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_FRAME = 9'h002,
    ST_SLEEP = 9'h004,
    ST_HOLD = 9'h008,
    ST_FLOAT = 9'h010,
    ST_SETTLE = 9'h020,
    ST_BURST = 9'h040,
    ST_CAL_GAP = 9'h080,
    ST_CAL_BURST = 9'h100
  } tsp_state_t;
endpackage : tsp_pkg

//--- rtl/tsp_sync.sv
`timescale 1ns/100ps
module tsp_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  // two flops; first stage is read only by the second
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage_reg <= '1;
      sync_out <= '1;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule : tsp_sync

//--- rtl/tsp_pos.sv
`timescale 1ns/100ps
module tsp_pos
  import tsp_pkg::*;
(
  input tsp_meas_t meas,
  input tsp_meas_t refv,
  input wire logic [7:0] threshold,
  output logic detect,
  output logic inverted,
  output logic [6:0] position
);
  // signed shift per channel: positive when touch lowers the count
  wire signed [MEAS_W:0] s1 = $signed({1'b0, refv.ch_left}) - $signed({1'b0, meas.ch_left});
  wire signed [MEAS_W:0] s2 = $signed({1'b0, refv.ch_right}) - $signed({1'b0, meas.ch_right});
  wire signed [MEAS_W:0] s3 = $signed({1'b0, refv.ch_ends}) - $signed({1'b0, meas.ch_ends});
  wire signed [MEAS_W:0] thr = $signed({{(MEAS_W-7){1'b0}}, threshold});
  wire signed [MEAS_W:0] s_max = (s1 > s2) ? ((s1 > s3) ? s1 : s3) : ((s2 > s3) ? s2 : s3);
  wire signed [MEAS_W:0] s_min = (s1 < s2) ? ((s1 < s3) ? s1 : s3) : ((s2 < s3) ? s2 : s3);
  wire [MEAS_W+1:0] spread = 18'(s_max - s_min);
  wire [MEAS_W-1:0] d1 = s1[MEAS_W] ? '0 : s1[MEAS_W-1:0];
  wire [MEAS_W-1:0] d2 = s2[MEAS_W] ? '0 : s2[MEAS_W-1:0];
  wire [MEAS_W-1:0] d3 = s3[MEAS_W] ? '0 : s3[MEAS_W-1:0];
  wire [6:0] end_w = (d1 >= d2) ? POS_LEFT : POS_RIGHT;
  wire [MEAS_W+8:0] num = 25'(d1 * POS_TAP_LEFT) + 25'(d2 * POS_TAP_RIGHT) + 25'(d3 * end_w);
  wire [MEAS_W+1:0] den = 18'(d1) + 18'(d2) + 18'(d3);
  wire [MEAS_W+8:0] raw = (den == '0) ? '0 : num / 25'(den);
  wire [6:0] raw7 = (raw > 25'(POS_RIGHT)) ? POS_RIGHT : raw[6:0];

  // imbalance only; an equal shift on all channels has zero spread (see RQ7)
  assign detect = $signed({1'b0, spread}) > $signed({{(MEAS_W-6){1'b0}}, threshold});
  assign inverted = (s1 < -thr) || (s2 < -thr) || (s3 < -thr);
  // end stops saturate outer zones (see RQ11)
  assign position = (raw7 <= POS_STOP_LO) ? POS_LEFT :
                    (raw7 >= POS_STOP_HI) ? POS_RIGHT : raw7;
endmodule : tsp_pos

//--- verif/tsp_host_model.sv
`timescale 1ns/100ps
module tsp_host_model (
  input wire logic sys_clk,
  output logic ss_n,
  output logic sclk,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);
  initial begin
    ss_n = 1'b1;
    sclk = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = 8'hff;
  end

  // select level, then n idle cycles
  task automatic sel(input logic lvl, input int n);
    @(negedge sys_clk);
    ss_n = lvl;
    repeat (n) @(negedge sys_clk);
  endtask : sel

  // link clock edges at 160 ns period, only inside a frame
  task automatic clocks(input int n);
    repeat (n) begin
      repeat (20) @(negedge sys_clk);
      if (ss_n === 1'b0) sclk = ~sclk;
    end
  endtask : clocks

  // one decoded command, code inverted once released
  task automatic cmd(input logic [7:0] code);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code = ~code;
  endtask : cmd
endmodule : tsp_host_model

//--- verif/tsp_top_tb_top.sv
`timescale 1ns/100ps
module tsp_top_tb_top
  import tsp_pkg::*;
;
  localparam int P_FLOAT = 20;
  localparam int P_SETTLE = 20;
  localparam int P_FREE = 200;
  localparam int P_GAP = 10;
  localparam int P_SLEEP = 30;
  localparam logic [15:0] B = 16'h1000;
  logic sys_clk, reset, ss_n_host, sclk, cmd_valid, burst_req, burst_done;
  logic ss_n_pin_out, ss_n_pin_oe, comm_ready_out, comm_ready_oe;
  logic touch_out, touch_oe, sleep_out, calibrating;
  logic [7:0] cmd_code, threshold, response_byte;
  logic [6:0] position_out;
  tsp_meas_t meas, burst_meas;
  wire ss_wire;
  int nbursts, fe_cnt, err_count, samples_checked;

  assign ss_wire = (ss_n_pin_oe === 1'b1) ? ss_n_pin_out : ss_n_host;
  assign burst_meas = burst_done ? meas : ~meas;

  tsp_host_model host (
    .sys_clk(sys_clk), .ss_n(ss_n_host), .sclk(sclk),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code)
  );

  tsp_top #(
    .T_FLOAT(P_FLOAT), .T_SETTLE(P_SETTLE), .T_FREERUN(P_FREE),
    .T_CAL_GAP(P_GAP), .T_SLEEP_ENTRY(P_SLEEP)
  ) uut (
    .sys_clk(sys_clk), .reset(reset), .ss_n_pin_in(ss_wire),
    .ss_n_pin_out(ss_n_pin_out), .ss_n_pin_oe(ss_n_pin_oe), .sclk_pin_in(sclk),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .threshold(threshold),
    .burst_req(burst_req), .burst_done(burst_done), .burst_meas(burst_meas),
    .comm_ready_out(comm_ready_out), .comm_ready_oe(comm_ready_oe),
    .touch_out(touch_out), .touch_oe(touch_oe), .sleep_out(sleep_out),
    .calibrating(calibrating), .position_out(position_out),
    .response_byte(response_byte)
  );

  // front end: answers each burst after four cycles
  always @(negedge sys_clk) begin
    burst_done <= 1'b0;
    if (burst_req !== 1'b1) fe_cnt <= 0;
    else if (fe_cnt == 3) begin
      burst_done <= 1'b1;
      fe_cnt <= 0;
      nbursts <= nbursts + 1;
    end else fe_cnt <= fe_cnt + 1;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic wait_more(input int n0, input int lim);
    for (int k = 0; k < lim && nbursts == n0; k++) @(negedge sys_clk);
    chk(8'(nbursts != n0), 8'h01, "burst");
    repeat (2) @(negedge sys_clk);
  endtask : wait_more

  task automatic status;
    host.sel(1'b0, 4);
    host.cmd(CMD_STATUS);
  endtask : status

  task automatic t_powerup;
    int bad;
    bad = 0;
    for (int k = 0; k < 2000 && calibrating === 1'b1; k++) begin
      @(negedge sys_clk);
      bad += (comm_ready_out !== 1'b0 && calibrating === 1'b1);
    end
    chk(8'(nbursts), 8'(CAL_BURSTS_PWR), "power up bursts");
    chk(8'(bad), 8'h00, "ready in cal");
    chk(comm_ready_out, 1'b1, "ready after cal");
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_pos(input logic [15:0] l, r, e, input logic [7:0] thr,
                       input logic det, input logic [6:0] pos);
    int n0;
    threshold = thr;
    meas = '{ch_left: B - l, ch_right: B - r, ch_ends: B - e};
    wait_more(nbursts, 400);
    chk(touch_out, det, "touch");
    chk(position_out, pos, "position");
    status;
    chk(response_byte[RESP_DETECT_BIT], det, "resp detect");
    chk(response_byte[RESP_ERROR_BIT], 1'b0, "resp error");
    n0 = nbursts;
    host.sel(1'b1, 0);
    wait_more(n0, 20);
    $display("test position done");
  endtask : t_pos

  task automatic t_sleep;
    int oe_n, fl_n, bat;
    oe_n = 0;
    fl_n = 0;
    bat = 0;
    host.sel(1'b0, 4);
    host.clocks(4);
    for (int k = 0; k < 200 && sleep_out !== 1'b1; k++) @(negedge sys_clk);
    repeat (20) @(negedge sys_clk);
    chk(sleep_out, 1'b1, "asleep");
    host.sel(1'b1, 0);
    for (int k = 1; k < 300; k++) begin
      @(negedge sys_clk);
      oe_n += (ss_n_pin_oe === 1'b1);
      fl_n += (touch_oe === 1'b0 && comm_ready_oe === 1'b0);
      if (burst_req === 1'b1 && bat == 0) bat = k;
    end
    chk(8'(oe_n), 8'(DIAG_CYC), "clamp length");
    chk(8'(fl_n), 8'(P_FLOAT), "float length");
    chk(8'(bat >= P_FLOAT + P_SETTLE && bat <= P_FLOAT + P_SETTLE + 8), 8'h01, "settle");
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_wake;
    int n0, bad;
    bad = 0;
    host.sel(1'b0, 4);
    host.clocks(2);
    for (int k = 0; k < 200 && sleep_out !== 1'b1; k++) @(negedge sys_clk);
    chk(sleep_out, 1'b1, "asleep before link clock");
    host.clocks(2);
    chk(sleep_out, 1'b0, "woken by link clock");
    for (int k = 0; k < 60; k++) begin
      @(negedge sys_clk);
      bad += (burst_req === 1'b1);
    end
    chk(8'(bad), 8'h00, "held for select");
    n0 = nbursts;
    host.sel(1'b1, 0);
    wait_more(n0, 300);
    $display("test wake done");
  endtask : t_wake

  task automatic t_drift;
    int n0;
    t_pos(16'd12, 16'd0, 16'd0, 8'h0a, 1'b1, POS_TAP_LEFT);
    host.sel(1'b0, 4);
    repeat (3) host.cmd(CMD_DRIFT);
    n0 = nbursts;
    host.sel(1'b1, 0);
    wait_more(n0, 20);
    chk(touch_out, 1'b0, "drift");
    $display("test drift done");
  endtask : t_drift

  task automatic t_cal(input logic [15:0] l);
    int n0, gap, mg, bad;
    logic seen;
    gap = 0;
    mg = 1000;
    bad = 0;
    seen = 1'b0;
    meas = '{ch_left: B - l, ch_right: B, ch_ends: B};
    host.sel(1'b0, 4);
    host.cmd(CMD_CAL);
    n0 = nbursts;
    host.sel(1'b1, 6);
    chk(calibrating, 1'b1, "cal start");
    for (int k = 0; k < 2000 && calibrating === 1'b1; k++) begin
      @(negedge sys_clk);
      bad += (comm_ready_out !== 1'b0 && calibrating === 1'b1);
      if (burst_req !== 1'b1) gap++;
      else if (gap > 0) begin
        if (seen && gap < mg) mg = gap;
        seen = 1'b1;
        gap = 0;
      end
    end
    chk(8'(nbursts - n0), 8'(CAL_BURSTS_CMD), "cal bursts");
    chk(8'(mg >= P_GAP), 8'h01, "cal spacing");
    chk(8'(bad), 8'h00, "ready in cal");
  endtask : t_cal

  task automatic t_err;
    t_cal(16'h0200);
    meas = '{ch_left: B, ch_right: B, ch_ends: B};
    wait_more(nbursts, 400);
    status;
    chk(response_byte[RESP_ERROR_BIT], 1'b1, "error set");
    host.sel(1'b1, 20);
    t_cal(16'h0000);
    status;
    chk(response_byte[RESP_ERROR_BIT], 1'b0, "error cleared");
    host.sel(1'b1, 20);
    $display("test error done");
  endtask : t_err

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    err_count++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    threshold = 8'h10;
    meas = '{ch_left: B, ch_right: B, ch_ends: B};
    nbursts = 0;
    fe_cnt = 0;
    burst_done = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    t_powerup();
    t_pos(16'd40, 16'd0, 16'd0, 8'h10, 1'b1, POS_TAP_LEFT);
    t_pos(16'd0, 16'd40, 16'd0, 8'h10, 1'b1, POS_TAP_RIGHT);
    t_pos(16'd40, 16'd40, 16'd40, 8'h10, 1'b0, POS_LEFT);
    t_pos(16'd10, 16'd0, 16'd100, 8'h10, 1'b1, POS_LEFT);
    t_pos(16'd0, 16'd10, 16'd100, 8'h10, 1'b1, POS_RIGHT);
    t_pos(16'd20, 16'd0, 16'd0, 8'h1e, 1'b0, POS_LEFT);
    t_pos(16'd0, 16'd0, 16'd0, 8'h10, 1'b0, POS_LEFT);
    t_sleep();
    t_wake();
    t_drift();
    t_err();
    conclude();
  end
endmodule : tsp_top_tb_top
